// *** bench/incremental_positioning_inpos_properties.sv ***
// Port checker for the positioning block
`timescale 1ns/1ps
`default_nettype none
// *************
// Port checker
// *************
module inpos_checker (
    // Clock and reset
    input wire logic core_clk,
    input wire logic nrst,
    // Bus
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic wb_ack_o,
    // Condition pins and outputs
    input wire logic warning_pin,
    input wire logic plus_overtravel_pin,
    input wire logic minus_overtravel_pin,
    input wire logic [7:0] fieldbus_out_image,
    input wire logic in_position_out
);
    logic [3:0] since_move; // Cycles since a move write
    wire move_req = wb_cyc_i & wb_stb_i & wb_we_i & ~wb_ack_o & (wb_adr_i[7:3] == 5'h00);
    // Saturating age counter
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            since_move <= 4'hf;
        end else begin
            since_move <= move_req ? 4'h0 : since_move + {3'h0, since_move != 4'hf};
        end
    end
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!nrst);
    ack_one_cycle_a: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack held too long");
    ack_answer_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o) else $error("no ack");
    dat_idle_a: assert property (!wb_ack_o |-> wb_dat_o == 32'h0) else $error("data outside ack");
    warn_detect_a: assert property (warning_pin [*8] |-> fieldbus_out_image[1]) else $error("warning lost");
    warn_clear_a: assert property (!warning_pin [*8] |-> !fieldbus_out_image[1]) else $error("warning stuck");
    plus_ot_a: assert property (plus_overtravel_pin [*8] |-> fieldbus_out_image[2]) else $error("plus lost");
    minus_ot_a: assert property (minus_overtravel_pin [*8] |-> fieldbus_out_image[3]) else $error("minus lost");
    busy_cause_a: assert property ($rose(fieldbus_out_image[5]) |-> since_move <= 4'h4) else $error("busy uncaused");
    inpos_idle_a: assert property (in_position_out && fieldbus_out_image[5] |=> !fieldbus_out_image[5]) else $error("inpos busy");
    cover property ($rose(fieldbus_out_image[5]));
    cover property ($rose(in_position_out));
    cover property (warning_pin [*8]);
endmodule
bind incremental_positioning_inpos inpos_checker chk_u (.core_clk, .nrst, .wb_cyc_i, .wb_stb_i, .wb_we_i,
    .wb_adr_i, .wb_dat_o, .wb_ack_o, .warning_pin, .plus_overtravel_pin, .minus_overtravel_pin,
    .fieldbus_out_image, .in_position_out);
`default_nettype wire

// *** bench/inpos_host.sv ***
// Bus master model for the host controller
`timescale 1ns/1ps
`default_nettype none
// ****************
// Host bus master
// ****************
module inpos_host (
    // Clock
    input wire logic core_clk,
    // Request
    output logic wb_cyc_i,
    output logic wb_stb_i,
    output logic wb_we_i,
    output logic [7:0] wb_adr_i,
    output logic [3:0] wb_sel_i,
    output logic [31:0] wb_dat_i,
    // Answer
    input wire logic [31:0] wb_dat_o,
    input wire logic wb_ack_o
);
    // Idle bus from time zero
    initial begin
        wb_cyc_i = 1'b0;
        wb_stb_i = 1'b0;
        wb_we_i = 1'b0;
        wb_adr_i = 8'h00;
        wb_sel_i = 4'h0;
        wb_dat_i = 32'h0;
    end
    // One classic cycle, held until ack is seen at a rising edge
    task automatic bus_cycle(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
        @(posedge core_clk);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= w;
        wb_adr_i <= a;
        wb_dat_i <= d;
        wb_sel_i <= 4'hf;
        do @(posedge core_clk); while (wb_ack_o !== 1'b1);
        q = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
    endtask
    task automatic wb_write(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        bus_cycle(1'b1, a, d, q);
    endtask
    task automatic wb_read(input logic [7:0] a, output logic [31:0] q);
        bus_cycle(1'b0, a, 32'h0, q);
    endtask
endmodule
`default_nettype wire

// *** bench/test_incremental_positioning_inpos.sv ***
// Self-checking bench for the positioning block
`timescale 1ns/1ps
`default_nettype none
`include "inpos_params.svh"
module test_incremental_positioning_inpos;
    logic core_clk = 1'b0;
    logic nrst = 1'b0;
    logic [16:0] ctrl_in_pins = 17'h0;
    logic [16:0] fieldbus_in_image = 17'h0;
    logic alarm_pin = 1'b0, warning_pin = 1'b0, plus_overtravel_pin = 1'b0, minus_overtravel_pin = 1'b0;
    logic other_motion_busy = 1'b0;
    wire logic wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, in_position_out, irq;
    wire logic [7:0] wb_adr_i, ctrl_out_pins, fieldbus_out_image;
    wire logic [3:0] wb_sel_i;
    wire logic [31:0] wb_dat_i, wb_dat_o;
    int err_count = 0, check_count = 0, cycles = 0, t0;
    always #12.5 core_clk = ~core_clk;
    inpos_host host_u (.core_clk, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i,
        .wb_dat_o, .wb_ack_o);
    incremental_positioning_inpos dut_u (.core_clk, .nrst, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
        .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .ctrl_in_pins, .fieldbus_in_image, .alarm_pin,
        .warning_pin, .plus_overtravel_pin, .minus_overtravel_pin, .other_motion_busy, .ctrl_out_pins,
        .fieldbus_out_image, .in_position_out, .irq);
    // ****************
    // Checks and waits
    // ****************
    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        check_count++;
        if (got !== exp) begin
            err_count++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp, input string what);
        logic [31:0] q;
        host_u.wb_read(a, q);
        check(what, exp, q);
    endtask
    task automatic settle();
        repeat (8) @(posedge core_clk);
    endtask
    // Poll busy with a bound
    task automatic wait_idle();
        logic [31:0] q = 32'h1;
        int n = 0;
        while (q[0] !== 1'b0 && n < 3000) begin
            host_u.wb_read(`REG_STATUS, q);
            n++;
        end
        check("busy", 32'h0, {31'h0, q[0]});
    endtask
    task automatic give_verdict();
        $display("Comparisons %0d mismatches %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    // Hang guard
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 60000) begin
            err_count++;
            give_verdict();
        end
    end
    // *********
    // Scenarios
    // *********
    initial begin
        repeat (4) @(posedge core_clk);
        nrst <= 1'b1;
        settle();
        rd_chk(`REG_INPOS_TIME, 32'h0, "stab default");
        rd_chk(8'h4c, 32'h0, "unmapped");
        host_u.wb_write(`REG_INPOS_TIME, 32'h1ffff);
        rd_chk(`REG_INPOS_TIME, 32'h186a0, "stab max");
        host_u.wb_write(`REG_INPOS_TIME, 32'h0);
        // Servo on, stop made active by polarity
        ctrl_in_pins <= 17'h00010;
        fieldbus_in_image <= 17'h10004;
        host_u.wb_write(`REG_IN_POLARITY, 32'h40);
        settle();
        rd_chk(`REG_IN_FUNC_MON, 32'h50, "in monitor");
        rd_chk(`REG_FB_IN_MON, 32'h10004, "fb in");
        host_u.wb_write(`REG_INCR_PULSE, 32'h64);
        rd_chk(`REG_IRQ_STATUS, 32'h2, "stop reject");
        rd_chk(`REG_POS_PULSE, 32'h0, "pos kept");
        host_u.wb_write(`REG_IN_POLARITY, 32'h0);
        fieldbus_in_image <= 17'h0;
        // One blocker at a time
        for (int i = 0; i < 5; i++) begin
            other_motion_busy <= (i == 0);
            alarm_pin <= (i == 1);
            warning_pin <= (i == 2);
            ctrl_in_pins <= (i == 3) ? 17'h0 : ((i == 4) ? 17'h11 : 17'h10);
            settle();
            host_u.wb_write(`REG_IRQ_STATUS, 32'h7);
            host_u.wb_write(`REG_INCR_PULSE, 32'h1);
            rd_chk(`REG_IRQ_STATUS, 32'h2, "blocked reject");
        end
        ctrl_in_pins <= 17'h10;
        plus_overtravel_pin <= 1'b1;
        minus_overtravel_pin <= 1'b1;
        settle();
        rd_chk(`REG_OUT_FUNC_MON, 32'hdd, "raw outputs");
        check("out pins", 32'hdddd, {16'h0, ctrl_out_pins, fieldbus_out_image});
        plus_overtravel_pin <= 1'b0;
        minus_overtravel_pin <= 1'b0;
        settle();
        check("overtravel off", 32'hd1d1, {16'h0, ctrl_out_pins, fieldbus_out_image});
        // Pulse limits, then a minus move
        host_u.wb_write(`REG_INCR_PULSE, 32'h0fa00001);
        host_u.wb_write(`REG_INCR_PULSE, 32'hf05fffff);
        rd_chk(`REG_IRQ_STATUS, 32'h2, "range reject");
        host_u.wb_write(`REG_INCR_PULSE, 32'hfffffff0);
        wait_idle();
        rd_chk(`REG_POS_PULSE, 32'hfffffff0, "pos pulse");
        check("in position", 32'h1, {31'h0, in_position_out});
        rd_chk(`REG_IRQ_STATUS, 32'h7, "events");
        check("irq masked", 32'h0, {31'h0, irq});
        host_u.wb_write(`REG_IRQ_MASK, 32'h4);
        settle();
        check("irq raised", 32'h1, {31'h0, irq});
        host_u.wb_write(`REG_IRQ_STATUS, 32'h7);
        settle();
        check("irq cleared", 32'h0, {31'h0, irq});
        // User move, one stability tick
        host_u.wb_write(`REG_USER_DIV, 32'hffff);
        host_u.wb_write(`REG_INPOS_TIME, 32'h1);
        host_u.wb_write(`REG_INCR_USER, 32'd6553501);
        rd_chk(`REG_IRQ_STATUS, 32'h2, "user reject");
        t0 = cycles;
        host_u.wb_write(`REG_INCR_USER, 32'h2);
        wait_idle();
        check("stab wait", 32'h1, {31'h0, (cycles - t0) >= `STAB_TICK_CYCLES});
        rd_chk(`REG_POS_PULSE, 32'h40, "pos user move");
        rd_chk(`REG_POS_USER, 32'h1, "pos user");
        give_verdict();
    end
endmodule
`default_nettype wire

// *** rtl/incremental_positioning_inpos.sv ***
// Incremental positioning, in-position detection and I/O monitors
//
// Implementation choices: the address map and the Wishbone interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "inpos_params.svh"
module incremental_positioning_inpos
    import inpos_pkg::*;
(
    // Clock and reset
    input wire logic core_clk,
    input wire logic nrst,
    // Wishbone classic slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // Control input pins and fieldbus remote input image
    input wire logic [`IN_FUNC_N-1:0] ctrl_in_pins,
    input wire logic [`IN_FUNC_N-1:0] fieldbus_in_image,
    // Drive condition pins
    input wire logic alarm_pin,
    input wire logic warning_pin,
    input wire logic plus_overtravel_pin,
    input wire logic minus_overtravel_pin,
    // Jog or home return running, from logic on this clock
    input wire logic other_motion_busy,
    // Control outputs, fieldbus output image, interrupt
    output logic [`OUT_FUNC_N-1:0] ctrl_out_pins,
    output logic [`OUT_FUNC_N-1:0] fieldbus_out_image,
    output logic in_position_out,
    output logic irq
);

    // ********************************
    // Reset release and pin synchronisers
    // ********************************
    logic [1:0] rst_sync;            // Release of reset through two flops
    wire rst_n = rst_sync[1];        // Reset copy used everywhere else

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            rst_sync <= 2'b00;
        end else begin
            rst_sync <= {rst_sync[0], 1'b1};
        end
    end

    localparam int PIN_N = 2 * `IN_FUNC_N + 4;
    logic [PIN_N-1:0] pin_meta;      // First stage, read only by pin_sync
    logic [PIN_N-1:0] pin_sync;      // Second stage, safe to use
    wire [PIN_N-1:0] pin_raw = {alarm_pin, warning_pin, plus_overtravel_pin, minus_overtravel_pin,
                                fieldbus_in_image, ctrl_in_pins};

    // Every outside pin passes two flops before any logic sees it
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            pin_meta <= '0;
            pin_sync <= '0;
        end else begin
            pin_meta <= pin_raw;
            pin_sync <= pin_meta;
        end
    end

    wire [`IN_FUNC_N-1:0] in_pin_s = pin_sync[`IN_FUNC_N-1:0];
    wire [`IN_FUNC_N-1:0] fb_in_s = pin_sync[2*`IN_FUNC_N-1:`IN_FUNC_N];
    wire alarm_s = pin_sync[PIN_N-1];
    wire warning_s = pin_sync[PIN_N-2];
    wire ot_plus_s = pin_sync[PIN_N-3];
    wire ot_minus_s = pin_sync[PIN_N-4];

    // ********************************
    // Helper functions
    // ********************************
    // Absolute value of a signed count
    function automatic logic [31:0] abs32(input logic signed [31:0] v);
        abs32 = v[31] ? 32'(-v) : 32'(v);
    endfunction

    // Byte-lane merge for writes with select
    function automatic logic [31:0] lane_merge(input logic [31:0] old, input logic [31:0] nw,
                                               input logic [3:0] sel);
        for (int b = 0; b < 4; b++) begin
            lane_merge[8*b +: 8] = sel[b] ? nw[8*b +: 8] : old[8*b +: 8];
        end
    endfunction

    // ********************************
    // Software registers
    // ********************************
    logic [15:0] user_division_number;                // Steps per revolution
    logic [`INPOS_WINDOW_W-1:0] inpos_window;         // In-position limit in pulses
    logic [`INPOS_TIME_W-1:0] inpos_stability_time;   // Tenths of a millisecond
    logic [`INPOS_WINDOW_W-1:0] near_window;          // Near-position limit in pulses
    logic [`IN_FUNC_N-1:0] input_polarity;            // 1 inverts the pin
    logic [`FILT_W-1:0] antichatter_timer;            // Cycles a new level must hold
    logic [`FILT_W-1:0] output_stability_timer;       // Cycles a state must hold
    logic [`OUT_FUNC_N-1:0] output_logic_invert;      // 1 inverts the pin
    logic [`IRQ_W-1:0] irq_status;                    // Sticky events
    logic [`IRQ_W-1:0] irq_mask;                      // 1 enables the event

    wire wb_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
    wire wb_wr = wb_req && wb_we_i;
    wire [31:0] wr_word = lane_merge(32'h00000000, wb_dat_i, wb_sel_i);
    wire [31:0] wr_mask = lane_merge(32'h00000000, 32'hffffffff, wb_sel_i);

    // Writes to the plain settings; the stability time saturates at its top value
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            user_division_number <= `USER_DIV_RST;
            inpos_window <= `INPOS_WINDOW_RST;
            inpos_stability_time <= `INPOS_TIME_RST;
            near_window <= `NEAR_WINDOW_RST;
            input_polarity <= '0;
            antichatter_timer <= '0;
            output_stability_timer <= '0;
            output_logic_invert <= '0;
            irq_mask <= '0;
        end else if (wb_wr) begin
            unique case (wb_adr_i)
                `REG_USER_DIV: user_division_number <= wr_word[15:0];
                `REG_INPOS_WINDOW: inpos_window <= wr_word[`INPOS_WINDOW_W-1:0];
                `REG_INPOS_TIME: inpos_stability_time <= (wr_word > 32'(`INPOS_TIME_MAX)) ?
                    `INPOS_TIME_MAX : wr_word[`INPOS_TIME_W-1:0];
                `REG_NEAR_WINDOW: near_window <= wr_word[`INPOS_WINDOW_W-1:0];
                `REG_IN_POLARITY: input_polarity <= wr_word[`IN_FUNC_N-1:0];
                `REG_ANTICHATTER: antichatter_timer <= wr_word[`FILT_W-1:0];
                `REG_OUT_STAB: output_stability_timer <= wr_word[`FILT_W-1:0];
                `REG_OUT_INVERT: output_logic_invert <= wr_word[`OUT_FUNC_N-1:0];
                `REG_IRQ_MASK: irq_mask <= wr_word[`IRQ_W-1:0];
                default: ;
            endcase
        end
    end

    // ********************************
    // Input function filtering
    // ********************************
    logic [`IN_FUNC_N-1:0] in_filt;   // Filtered, polarity-applied pin functions

    genvar gi;
    generate
        for (gi = 0; gi < `IN_FUNC_N; gi++) begin : g_in_filt
            logic [`FILT_W-1:0] cnt;  // Cycles the new level has held
            wire lvl = in_pin_s[gi] ^ input_polarity[gi];
            // A new level is taken only once it has held for the anti-chatter time
            always_ff @(posedge core_clk or negedge rst_n) begin
                if (!rst_n) begin
                    cnt <= '0;
                    in_filt[gi] <= 1'b0;
                end else if (lvl == in_filt[gi]) begin
                    cnt <= '0;
                end else if (cnt >= antichatter_timer) begin
                    cnt <= '0;
                    in_filt[gi] <= lvl;
                end else begin
                    cnt <= cnt + 8'h01;
                end
            end
        end
    endgenerate

    // Fieldbus inputs act alongside the pins on fitted variants
    wire [`IN_FUNC_N-1:0] fb_in_eff = `FIELDBUS_FITTED ? fb_in_s : '0;
    wire [`IN_FUNC_N-1:0] in_func = in_filt | fb_in_eff;
    wire servo_on = in_func[`IN_SERVO_ON];
    wire stop_active = in_func[`IN_STOP] | in_func[`IN_EMERG_STOP];

    // ********************************
    // Move decode and acceptance
    // ********************************
    motion_state_t state;
    motion_state_t next_state;
    logic signed [31:0] cmd_pos;      // Commanded position in pulses
    logic signed [31:0] act_pos;      // Actual position in pulses
    logic [7:0] step_div;             // Divider for the step enable
    wire step_en = (step_div == `STEP_DIV - 8'h01);

    wire [31:0] div_ext = {16'h0000, user_division_number};
    wire [31:0] user_mag = abs32(wb_dat_i);
    wire user_ok = (user_division_number != 16'h0000) &&
                   (user_mag <= 32'(div_ext * `USER_SCALE_LIMIT));
    wire pulse_ok = abs32(wb_dat_i) <= `PULSE_MOVE_MAX;
    wire signed [63:0] user_prod = 64'(signed'(wb_dat_i)) * 64'(signed'(`PULSES_PER_REV));
    wire signed [63:0] user_pulses = user_prod / 64'(signed'(div_ext));

    move_cmd_t move;                  // Move written this cycle
    assign move.valid = wb_wr && wb_sel_i == 4'hf &&
                        (wb_adr_i == `REG_INCR_USER || wb_adr_i == `REG_INCR_PULSE);
    assign move.user_scale = (wb_adr_i == `REG_INCR_USER);
    assign move.data = move.user_scale ? user_pulses[31:0] : wb_dat_i;

    wire ready_to_move = servo_on && state == ST_IDLE && !other_motion_busy &&
                         !alarm_s && !warning_s && !stop_active;
    wire range_ok = move.user_scale ? user_ok : pulse_ok;
    wire accept = move.valid && ready_to_move && range_ok;
    wire reject = move.valid && !accept;

    // ********************************
    // Motion sequencer
    // ********************************
    wire signed [31:0] pos_err = cmd_pos - act_pos;
    wire [31:0] err_mag = abs32(pos_err);
    wire in_window = err_mag <= {10'h000, inpos_window};
    wire in_near = err_mag <= {10'h000, near_window};
    logic inpos_done;                 // Stability time met

    // Next state; a refused move never moves the sequencer
    always_comb begin
        next_state = state;
        unique case (state)
            ST_IDLE: if (accept) next_state = ST_MOVING;
            ST_MOVING: if (pos_err == 32'sd0) next_state = ST_SETTLE;
            ST_SETTLE: if (inpos_done) next_state = ST_IDLE;
            default: next_state = ST_IDLE;
        endcase
    end

    // Positions; the actual one walks toward the command one pulse per step enable
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            state <= ST_IDLE;
            cmd_pos <= 32'sd0;
            act_pos <= 32'sd0;
            step_div <= 8'h00;
        end else begin
            state <= next_state;
            step_div <= step_en ? 8'h00 : step_div + 8'h01;
            if (accept) begin
                cmd_pos <= cmd_pos + signed'(move.data);
            end
            if (step_en && pos_err != 32'sd0) begin
                act_pos <= pos_err[31] ? act_pos - 32'sd1 : act_pos + 32'sd1;
            end
        end
    end

    // Position readouts; the user value is rescaled from pulses
    wire signed [63:0] pos_user_prod = 64'(act_pos) * 64'(signed'(div_ext));
    wire signed [63:0] pos_user = pos_user_prod / 64'(signed'(`PULSES_PER_REV));

    // ********************************
    // In-position stability timer
    // ********************************
    logic [`STAB_TICK_W-1:0] tick_cnt;   // Cycles inside one 0.1 ms tick
    logic [`INPOS_TIME_W-1:0] stab_cnt;  // Whole ticks spent in the window
    wire tick = (tick_cnt == `STAB_TICK_W'(`STAB_TICK_CYCLES - 1));
    assign inpos_done = in_window && stab_cnt >= inpos_stability_time;

    // Both counters restart on leaving the window, so no partial tick counts
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            tick_cnt <= '0;
            stab_cnt <= '0;
            in_position_out <= 1'b0;
        end else begin
            if (!in_window || accept) begin
                tick_cnt <= '0;
                stab_cnt <= '0;
            end else begin
                tick_cnt <= tick ? '0 : tick_cnt + `STAB_TICK_W'(1);
                if (tick && stab_cnt != `INPOS_TIME_MAX) begin
                    stab_cnt <= stab_cnt + `INPOS_TIME_W'(1);
                end
            end
            in_position_out <= inpos_done && state != ST_MOVING && !accept;
        end
    end

    // ********************************
    // Output functions and pins
    // ********************************
    out_func_t out_func;              // Raw detected states
    assign out_func.driver_ready_out = !alarm_s;
    assign out_func.warning_out = warning_s;
    assign out_func.plus_overtravel_out = ot_plus_s;
    assign out_func.minus_overtravel_out = ot_minus_s;
    assign out_func.servo_state_out = servo_on;
    assign out_func.busy = (state != ST_IDLE);
    assign out_func.in_position_out = in_position_out;
    assign out_func.near_position_out = in_near;
    wire [`OUT_FUNC_N-1:0] out_raw = out_func;

    generate
        for (gi = 0; gi < `OUT_FUNC_N; gi++) begin : g_out_stab
            logic [`FILT_W-1:0] cnt;  // Cycles the new state has held
            logic held;               // State after the stability timer
            // The pin follows only a state that has held for the stability time
            always_ff @(posedge core_clk or negedge rst_n) begin
                if (!rst_n) begin
                    cnt <= '0;
                    held <= 1'b0;
                    ctrl_out_pins[gi] <= 1'b0;
                end else begin
                    if (out_raw[gi] == held) begin
                        cnt <= '0;
                    end else if (cnt >= output_stability_timer) begin
                        cnt <= '0;
                        held <= out_raw[gi];
                    end else begin
                        cnt <= cnt + 8'h01;
                    end
                    ctrl_out_pins[gi] <= held ^ output_logic_invert[gi];
                end
            end
        end
    endgenerate

    // Fieldbus output image carries raw detected states
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            fieldbus_out_image <= '0;
        end else begin
            fieldbus_out_image <= `FIELDBUS_FITTED ? out_raw : '0;
        end
    end

    // ********************************
    // Interrupts
    // ********************************
    wire inpos_rise = inpos_done && state == ST_SETTLE;
    wire [`IRQ_W-1:0] irq_event = {inpos_rise, reject, accept};
    wire [`IRQ_W-1:0] irq_clear = (wb_wr && wb_adr_i == `REG_IRQ_STATUS) ?
                                  wr_word[`IRQ_W-1:0] : '0;

    // A new event wins over a clear in the same cycle
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            irq_status <= '0;
            irq <= 1'b0;
        end else begin
            irq_status <= (irq_status & ~irq_clear) | irq_event;
            irq <= |(irq_status & irq_mask);
        end
    end

    // ********************************
    // Read data and acknowledge
    // ********************************
    logic [31:0] rd_word;             // Selected read value
    always_comb begin
        unique case (wb_adr_i)
            `REG_USER_DIV: rd_word = div_ext;
            `REG_INPOS_WINDOW: rd_word = 32'(inpos_window);
            `REG_INPOS_TIME: rd_word = 32'(inpos_stability_time);
            `REG_NEAR_WINDOW: rd_word = 32'(near_window);
            `REG_IN_POLARITY: rd_word = 32'(input_polarity);
            `REG_ANTICHATTER: rd_word = 32'(antichatter_timer);
            `REG_OUT_STAB: rd_word = 32'(output_stability_timer);
            `REG_OUT_INVERT: rd_word = 32'(output_logic_invert);
            `REG_POS_PULSE: rd_word = act_pos;
            `REG_POS_USER: rd_word = pos_user[31:0];
            `REG_IN_FUNC_MON: rd_word = 32'(in_filt);
            `REG_OUT_FUNC_MON: rd_word = 32'(out_raw);
            `REG_FB_IN_MON: rd_word = 32'(fb_in_eff);
            `REG_FB_OUT_MON: rd_word = `FIELDBUS_FITTED ? 32'(out_raw) : 32'h00000000;
            `REG_STATUS: rd_word = {26'h0, state, 1'b0, ready_to_move, in_position_out, out_func.busy};
            `REG_IRQ_STATUS: rd_word = 32'(irq_status);
            `REG_IRQ_MASK: rd_word = 32'(irq_mask);
            default: rd_word = 32'h00000000;
        endcase
    end

    // One-cycle answer to every access, unmapped ones read zero
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h00000000;
        end else begin
            wb_ack_o <= wb_req;
            wb_dat_o <= (wb_req && !wb_we_i) ? rd_word : 32'h00000000;
        end
    end

endmodule
`default_nettype wire

// *** rtl/inpos_params.svh ***
// Constants for the incremental positioning and in-position block
`ifndef INPOS_PARAMS_SVH
`define INPOS_PARAMS_SVH

// Clock and stability timer base
`define CORE_CLK_PERIOD_NS 25
`define STAB_TICK_NS 100000
`define STAB_TICK_CYCLES (`STAB_TICK_NS / `CORE_CLK_PERIOD_NS)
`define STAB_TICK_W 12
`define INPOS_TIME_W 17
`define INPOS_TIME_MAX 17'h186a0
`define INPOS_TIME_RST 17'h00000

// Position scaling
`define PULSES_PER_REV 32'h00280000
`define PULSE_MOVE_MAX 32'h0fa00000
`define USER_SCALE_LIMIT 32'h00000064
`define USER_DIV_RST 16'h0168
`define INPOS_WINDOW_W 22
`define INPOS_WINDOW_RST 22'h000190
`define NEAR_WINDOW_RST 22'h000fa0
`define STEP_DIV 8'h04

// Pin counts and filter widths
`define IN_FUNC_N 17
`define OUT_FUNC_N 8
`define FILT_W 8
`define FIELDBUS_FITTED 1'b1

// Register byte offsets
`define REG_INCR_USER 8'h00
`define REG_INCR_PULSE 8'h04
`define REG_USER_DIV 8'h08
`define REG_INPOS_WINDOW 8'h0c
`define REG_INPOS_TIME 8'h10
`define REG_NEAR_WINDOW 8'h14
`define REG_IN_POLARITY 8'h18
`define REG_ANTICHATTER 8'h1c
`define REG_OUT_STAB 8'h20
`define REG_OUT_INVERT 8'h24
`define REG_POS_PULSE 8'h28
`define REG_POS_USER 8'h2c
`define REG_IN_FUNC_MON 8'h30
`define REG_OUT_FUNC_MON 8'h34
`define REG_FB_IN_MON 8'h38
`define REG_FB_OUT_MON 8'h3c
`define REG_STATUS 8'h40
`define REG_IRQ_STATUS 8'h44
`define REG_IRQ_MASK 8'h48

// Input function bit positions
`define IN_EMERG_STOP 0
`define IN_ALARM_CLEAR 1
`define IN_SERVO_ON 4
`define IN_RUN 5
`define IN_STOP 6
`define IN_PROG_SEL_LO 7
`define IN_JOG 15
`define IN_DIR 16

// Interrupt bits
`define IRQ_W 3
`define IRQ_ACCEPT 0
`define IRQ_REJECT 1
`define IRQ_INPOS 2

`endif

// *** rtl/inpos_pkg.sv ***
// Types for the incremental positioning and in-position block
package inpos_pkg;

    // Motion sequencer, Gray coded along idle, moving, settling
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_MOVING = 2'b01,
        ST_SETTLE = 2'b11
    } motion_state_t;

    // Output function image, bit 7 first
    typedef struct packed {
        logic near_position_out;
        logic in_position_out;
        logic busy;
        logic servo_state_out;
        logic minus_overtravel_out;
        logic plus_overtravel_out;
        logic warning_out;
        logic driver_ready_out;
    } out_func_t;

    // Move request decoded from a register write
    typedef struct packed {
        logic valid;
        logic user_scale;
        logic [31:0] data;
    } move_cmd_t;

endpackage
